// [fault_thermal_status_bank.v]
// sticky bank of power fault, thermal and overcurrent status flags
// assumes a simple internal register port from the serial control logic;
// event inputs are raw levels from analog detectors, asynchronous to mclk
// read and write strobes never coincide; the serial logic keeps them apart
// an event level must stand two cycles or more, or it may be missed
`timescale 1ns/1ps
`include "fault_bank_defines.vh"

module fault_thermal_status_bank (
  mclk,
  nrst,
  aux_one_regulation_lost,
  termination_regulation_lost,
  switch_second_regulation_lost,
  switch_first_regulation_lost,
  aux_three_regulation_lost,
  site_critical,
  site_warm,
  first_controller_overcurrent,
  second_controller_overcurrent,
  sixth_controller_overcurrent,
  reg_addr,
  reg_wr,
  reg_rd,
  reg_wdata,
  reg_rdata,
  reg_rvalid,
  reg_hit
);
  input  wire                        mclk;
  input  wire                        nrst;
  input  wire                        aux_one_regulation_lost;
  input  wire                        termination_regulation_lost;
  input  wire                        switch_second_regulation_lost;
  input  wire                        switch_first_regulation_lost;
  input  wire                        aux_three_regulation_lost;
  input  wire [`NUM_TEMP_SITES-1:0]  site_critical;  // bit order as register
  input  wire [`NUM_TEMP_SITES-1:0]  site_warm;      // bit order as register
  input  wire                        first_controller_overcurrent;
  input  wire                        second_controller_overcurrent;
  input  wire                        sixth_controller_overcurrent;
  input  wire [7:0]                  reg_addr;
  input  wire                        reg_wr;
  input  wire                        reg_rd;
  input  wire [7:0]                  reg_wdata;
  output reg  [7:0]                  reg_rdata;
  output reg                         reg_rvalid;
  output reg                         reg_hit;

  // ----------------------------------------
  // port timing
  // ----------------------------------------
  // one strobe per cycle, never read and write together
  // answer on the next edge: rvalid and hit for one cycle
  // rdata keeps the last read word until the next read
  // unmapped addresses give no hit and read as zero
  // a zero bit in a write leaves its flag alone
  // an event reaches its flag five edges after it rises
  // a condition still present sets its flag again at once,
  // so software must remove the cause before clearing

  // one-hot register selects, bit order follows the offsets
  localparam [3:0] SEL_NONE = 4'h0;
  localparam [3:0] SEL_PWR  = 4'h1;
  localparam [3:0] SEL_CRIT = 4'h2;
  localparam [3:0] SEL_HOT  = 4'h4;
  localparam [3:0] SEL_OC   = 4'h8;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // returns the one-hot register select for an address;
  // used by the strobes and by the hit flag
  function [3:0] decode;
    input [7:0] addr;
    begin
      case (addr)
        `OFS_PWR_FAULT_SECOND: decode = SEL_PWR;
        `OFS_THERM_CRIT:       decode = SEL_CRIT;
        `OFS_THERM_HOT:        decode = SEL_HOT;
        `OFS_OVERCURRENT:      decode = SEL_OC;
        default:               decode = SEL_NONE;
      endcase
    end
  endfunction

  // ----------------------------------------
  // implemented bit masks
  // ----------------------------------------
  // reserved positions kept out
  // the sub-registers are narrow already; the mask keeps the
  // reserved bits dead on both the clear and the read path
  function [7:0] impl_mask;
    input [3:0] sel;
    begin
      case (sel)
        SEL_PWR:  impl_mask = {{(8-`W_PWR_FAULT){1'b0}}, {`W_PWR_FAULT{1'b1}}};
        SEL_CRIT: impl_mask = {{(8-`W_THERM){1'b0}}, {`W_THERM{1'b1}}};
        SEL_HOT:  impl_mask = {{(8-`W_THERM){1'b0}}, {`W_THERM{1'b1}}};
        SEL_OC:   impl_mask = {{(8-`W_OVERCURRENT){1'b0}}, {`W_OVERCURRENT{1'b1}}};
        default:  impl_mask = 8'h00;
      endcase
    end
  endfunction

  wire [3:0] wr_sel;
  wire [3:0] rd_sel;

  assign wr_sel = reg_wr ? decode(reg_addr) : SEL_NONE;
  assign rd_sel = reg_rd ? decode(reg_addr) : SEL_NONE;

  wire [7:0] clr_data;

  assign clr_data = reg_wdata & impl_mask(wr_sel);

  // ----------------------------------------
  // event gathering
  // ----------------------------------------
  // discrete rail and buck inputs packed in register order
  wire [`W_PWR_FAULT-1:0]   pwr_raw;
  wire [`W_OVERCURRENT-1:0] oc_raw;

  assign pwr_raw[`BIT_AUX_ONE]       = aux_one_regulation_lost;
  assign pwr_raw[`BIT_TERM_REG]      = termination_regulation_lost;
  assign pwr_raw[`BIT_SWITCH_SECOND] = switch_second_regulation_lost;
  assign pwr_raw[`BIT_SWITCH_FIRST]  = switch_first_regulation_lost;
  assign pwr_raw[`BIT_AUX_THREE]     = aux_three_regulation_lost;

  assign oc_raw[`BIT_BUCK_SIXTH]  = sixth_controller_overcurrent;
  assign oc_raw[`BIT_BUCK_SECOND] = second_controller_overcurrent;
  assign oc_raw[`BIT_BUCK_FIRST]  = first_controller_overcurrent;

  // event levels after the synchronisers
  wire [`W_PWR_FAULT-1:0]   pwr_lvl;
  wire [`W_THERM-1:0]       crit_lvl;
  wire [`W_THERM-1:0]       hot_lvl;
  wire [`W_OVERCURRENT-1:0] oc_lvl;

  // detectors are analog, so every event crosses into mclk first
  // a change counts once two stages agree, so one-cycle noise is dropped
  event_sync #(
    .WIDTH (`W_PWR_FAULT)
  ) u_sync_pwr (
    .mclk      (mclk),
    .nrst      (nrst),
    .async_in  (pwr_raw),
    .level_out (pwr_lvl)
  );

  // sites feed bits in register order
  event_sync #(
    .WIDTH (`W_THERM)
  ) u_sync_crit (
    .mclk      (mclk),
    .nrst      (nrst),
    .async_in  (site_critical),
    .level_out (crit_lvl)
  );

  event_sync #(
    .WIDTH (`W_THERM)
  ) u_sync_hot (
    .mclk      (mclk),
    .nrst      (nrst),
    .async_in  (site_warm),
    .level_out (hot_lvl)
  );

  event_sync #(
    .WIDTH (`W_OVERCURRENT)
  ) u_sync_oc (
    .mclk      (mclk),
    .nrst      (nrst),
    .async_in  (oc_raw),
    .level_out (oc_lvl)
  );

  // ----------------------------------------
  // sticky flag registers
  // ----------------------------------------
  // one instance per register; a set beats a clear in the same cycle
  // flag words as they read, reserved bits added at the mux
  wire [`W_PWR_FAULT-1:0]   pwr_flags;
  wire [`W_THERM-1:0]       crit_flags;
  wire [`W_THERM-1:0]       hot_flags;
  wire [`W_OVERCURRENT-1:0] oc_flags;

  // regulation loss flags, write one clears
  // the clear uses the masked write word, never the raw bus
  sticky_reg #(
    .WIDTH (`W_PWR_FAULT)
  ) u_pwr (
    .mclk      (mclk),
    .nrst      (nrst),
    .event_lvl (pwr_lvl),
    .clr_en    (wr_sel[0]),
    .clr_mask  (clr_data[`W_PWR_FAULT-1:0]),
    .flags     (pwr_flags)
  );

  // critical temperature flags
  // sensor order equals bit order, so no remap here
  sticky_reg #(
    .WIDTH (`W_THERM)
  ) u_crit (
    .mclk      (mclk),
    .nrst      (nrst),
    .event_lvl (crit_lvl),
    .clr_en    (wr_sel[1]),
    .clr_mask  (clr_data[`W_THERM-1:0]),
    .flags     (crit_flags)
  );

  // hot temperature flags
  // a site can be hot and critical at once; both flags latch
  sticky_reg #(
    .WIDTH (`W_THERM)
  ) u_hot (
    .mclk      (mclk),
    .nrst      (nrst),
    .event_lvl (hot_lvl),
    .clr_en    (wr_sel[2]),
    .clr_mask  (clr_data[`W_THERM-1:0]),
    .flags     (hot_flags)
  );

  // low-side driver overcurrent flags
  // only three controllers are watched; bits 7..3 read zero
  sticky_reg #(
    .WIDTH (`W_OVERCURRENT)
  ) u_oc (
    .mclk      (mclk),
    .nrst      (nrst),
    .event_lvl (oc_lvl),
    .clr_en    (wr_sel[3]),
    .clr_mask  (clr_data[`W_OVERCURRENT-1:0]),
    .flags     (oc_flags)
  );

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  reg [7:0] nxt_rdata;

  // reserved upper bits padded with zero, writes never reach them
  always @* begin
    nxt_rdata = 8'h00;
    case (rd_sel)
      SEL_PWR: nxt_rdata = {3'h0, pwr_flags};
      SEL_CRIT: nxt_rdata = {3'h0, crit_flags};
      SEL_HOT: nxt_rdata = {3'h0, hot_flags};
      SEL_OC: nxt_rdata = {5'h00, oc_flags};
      default: nxt_rdata = 8'h00;
    endcase
    // mask again so no field leaks into a reserved bit
    nxt_rdata = nxt_rdata & impl_mask(rd_sel);
  end

  // ----------------------------------------
  // registered answer
  // ----------------------------------------
  // read data is a snapshot of the flags in the request cycle
  // rdata is left alone on other cycles, so a slow serial side
  // can shift it out at leisure; rvalid marks the fresh word
  // hit covers writes as well, so a write can be confirmed
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
      reg_hit    <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      reg_hit    <= ((reg_rd | reg_wr) && (decode(reg_addr) != 4'h0));
      if (reg_rd) begin
        reg_rdata <= nxt_rdata;
      end
    end
  end

endmodule // fault_thermal_status_bank

// [fault_bank_defines.vh]
// constants for the fault, thermal and overcurrent status bank
// assumes inclusion by bare name from the design files
`ifndef FAULT_BANK_DEFINES_VH
`define FAULT_BANK_DEFINES_VH

// register offsets on the internal register port
`define OFS_PWR_FAULT_SECOND 8'hb3
`define OFS_THERM_CRIT       8'hb4
`define OFS_THERM_HOT        8'hb5
`define OFS_OVERCURRENT      8'hb6

// reset values
`define RST_PWR_FAULT_SECOND 8'h00
`define RST_THERM_CRIT       8'h00
`define RST_THERM_HOT        8'h00
`define RST_OVERCURRENT      8'h00

// implemented field widths (bits above are reserved)
`define W_PWR_FAULT          5
`define W_THERM              5
`define W_OVERCURRENT        3

// power fault field positions
`define BIT_AUX_ONE          4
`define BIT_TERM_REG         3
`define BIT_SWITCH_SECOND    2
`define BIT_SWITCH_FIRST     1
`define BIT_AUX_THREE        0

// thermal site positions, shared by critical and hot
`define BIT_REST_OF_DIE      4
`define BIT_TERM_SITE        3
`define BIT_UPPER_RIGHT      2
`define BIT_UPPER_LEFT       1
`define BIT_LOWER_RIGHT      0

// overcurrent positions
`define BIT_BUCK_SIXTH       2
`define BIT_BUCK_SECOND      1
`define BIT_BUCK_FIRST       0

// number of on-die temperature sensors
`define NUM_TEMP_SITES       5

`endif

// [event_sync.v]
// three-stage synchroniser with agreement filter for a bus of event levels
// assumes inputs are asynchronous to mclk; output is a clean level
`timescale 1ns/1ps

module event_sync #(
  parameter WIDTH = 5
) (
  mclk,
  nrst,
  async_in,
  level_out
);
  input  wire             mclk;
  input  wire             nrst;
  input  wire [WIDTH-1:0] async_in;
  output reg  [WIDTH-1:0] level_out;

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_a_ff;
  reg [WIDTH-1:0] sync_b_ff;

  // ----------------------------------------
  // synchroniser chain
  // ----------------------------------------
  // first stage is read only by the second
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_ff   <= {WIDTH{1'b0}};
      sync_a_ff <= {WIDTH{1'b0}};
      sync_b_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff   <= async_in;
      sync_a_ff <= meta_ff;
      sync_b_ff <= sync_a_ff;
    end
  end

  // ----------------------------------------
  // agreement filter
  // ----------------------------------------
  // a change counts only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_agree
      always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          level_out[i] <= 1'b0;
        end else if (sync_a_ff[i] == sync_b_ff[i]) begin
          level_out[i] <= sync_b_ff[i];
        end
      end
    end
  endgenerate

endmodule // event_sync

// [sticky_reg.v]
// one sticky status register, write one to clear
// assumes event levels already in mclk domain; reserved bits handled by caller
`timescale 1ns/1ps

module sticky_reg #(
  parameter WIDTH = 5
) (
  mclk,
  nrst,
  event_lvl,
  clr_en,
  clr_mask,
  flags
);
  input  wire             mclk;
  input  wire             nrst;
  input  wire [WIDTH-1:0] event_lvl;
  input  wire             clr_en;
  input  wire [WIDTH-1:0] clr_mask;
  output wire [WIDTH-1:0] flags;

  reg  [WIDTH-1:0] flags_ff;
  wire [WIDTH-1:0] nxt_flags;

  // set wins over clear so an event in the clearing cycle survives
  // latch until cleared
  assign nxt_flags = event_lvl | (flags_ff & ~(clr_en ? clr_mask : {WIDTH{1'b0}}));

  // ----------------------------------------
  // flag storage
  // ----------------------------------------
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flags_ff <= {WIDTH{1'b0}};
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags = flags_ff;

endmodule // sticky_reg

// [fault_bank_properties.sv]
// timing checks on the register port of the status bank
// assumes binding onto the bank top, every port by name
`timescale 1ns/1ps

module fault_bank_properties (
  input wire       mclk,
  input wire       nrst,
  input wire [4:0] site_critical,
  input wire [7:0] reg_addr,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       reg_rvalid,
  input wire       reg_hit
);
  // --------------------------------
  // helpers
  // --------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire mapped = (reg_addr >= 8'hb3) && (reg_addr <= 8'hb6);
  // eight cycles covers the sync delay with margin
  sequence site_held;
    site_critical[0] [*8];
  endsequence
  sequence crit_read;
    reg_rd && (reg_addr == 8'hb4);
  endsequence
  // --------------------------------
  // assertions
  // --------------------------------
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read gave no valid");
  no_spurious_valid_a: assert property (!reg_rd |=> !reg_rvalid)
    else $error("valid without read");
  mapped_hit_a: assert property ((reg_rd || reg_wr) && mapped |=> reg_hit)
    else $error("hit missing");
  unmapped_quiet_a: assert property (!((reg_rd || reg_wr) && mapped) |=> !reg_hit)
    else $error("stray hit");
  reserved_low_a: assert property (reg_rd && mapped && reg_addr != 8'hb6 |=> reg_rdata[7:5] == 3'h0)
    else $error("reserved bits set");
  oc_reserved_a: assert property (reg_rd && reg_addr == 8'hb6 |=> reg_rdata[7:3] == 5'h00)
    else $error("oc reserved set");
  unmapped_zero_a: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
    else $error("hole read nonzero");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  crit_latch_a: assert property (site_held ##0 crit_read |=> reg_rdata[0])
    else $error("critical flag not set");
endmodule // fault_bank_properties

bind fault_thermal_status_bank fault_bank_properties u_props (
  .mclk          (mclk),
  .nrst          (nrst),
  .site_critical (site_critical),
  .reg_addr      (reg_addr),
  .reg_wr        (reg_wr),
  .reg_rd        (reg_rd),
  .reg_rdata     (reg_rdata),
  .reg_rvalid    (reg_rvalid),
  .reg_hit       (reg_hit)
);

// [host_port_model.sv]
// host side of the internal register port
// assumes mclk from the bench; one request per task call
`timescale 1ns/1ps

module host_port_model (
  input  wire       mclk,
  input  wire [7:0] reg_rdata,
  input  wire       reg_rvalid,
  input  wire       reg_hit,
  output reg  [7:0] reg_addr,
  output reg        reg_wr,
  output reg        reg_rd,
  output reg  [7:0] reg_wdata
);
  // --------------------------------
  // idle state
  // --------------------------------
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // host writes ones to clear
  // released lines show the inverse so stale values never match
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge mclk);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
    end
  endtask
  // read returns valid, hit and data of the answer cycle
  task rd(input [7:0] a, output [9:0] r);
    begin
      @(posedge mclk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge mclk);
      #1;
      r = {reg_rvalid, reg_hit, reg_rdata};
      reg_rd = 1'b0;
      reg_addr = ~a;
    end
  endtask
endmodule // host_port_model

// [test_fault_thermal_status_bank.sv]
// self-checking bench for the status bank
// assumes the host model drives the register port, bench drives events
`timescale 1ns/1ps

module test_fault_thermal_status_bank;
  reg         mclk;
  reg         nrst;
  reg  [17:0] ev;
  wire [7:0]  reg_addr;
  wire        reg_wr;
  wire        reg_rd;
  wire [7:0]  reg_wdata;
  wire [7:0]  reg_rdata;
  wire        reg_rvalid;
  wire        reg_hit;
  reg  [9:0]  r;
  reg  [7:0]  k;
  integer     failures;
  integer     checked;
  integer     i;
  // --------------------------------
  // instances
  // --------------------------------
  fault_thermal_status_bank u_dut (
    .mclk(mclk), .nrst(nrst),
    .aux_one_regulation_lost(ev[4]), .termination_regulation_lost(ev[3]),
    .switch_second_regulation_lost(ev[2]), .switch_first_regulation_lost(ev[1]),
    .aux_three_regulation_lost(ev[0]), .site_critical(ev[9:5]), .site_warm(ev[14:10]),
    .first_controller_overcurrent(ev[15]), .second_controller_overcurrent(ev[16]),
    .sixth_controller_overcurrent(ev[17]), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit));
  host_port_model u_host (
    .mclk(mclk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  // --------------------------------
  // tasks
  // --------------------------------
  task check(input [9:0] seen, input [9:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task rd_chk(input [7:0] a, input [9:0] exp);
    begin
      u_host.rd(a, r);
      check(r, exp);
    end
  endtask
  // write, then look at hit while it stands
  task wr_chk(input [7:0] a, input [7:0] d, input h);
    begin
      u_host.wr(a, d);
      check({9'h000, reg_hit}, {9'h000, h});
    end
  endtask
  task tally_and_finish;
    begin
      if (failures == 0 && checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // clock, 4 ns period
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // watchdog cuts a hang short
  initial begin
    repeat (5000) @(posedge mclk);
    failures = failures + 1;
    tally_and_finish;
  end
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    nrst = 1'b0;
    ev = 18'h0;
    failures = 0;
    checked = 0;
    repeat (6) @(posedge mclk);
    #1 nrst = 1'b1;
    // reset values and holes
    for (i = 8'hb2; i <= 8'hb7; i = i + 1)
      rd_chk(i[7:0], {1'b1, i >= 8'hb3 && i <= 8'hb6, 8'h00});
    // each event alone, latched after it goes
    for (i = 0; i < 18; i = i + 1) begin
      k = (i < 5) ? 8'd0 : (i < 10) ? 8'd1 : (i < 15) ? 8'd2 : 8'd3;
      ev[i] = 1'b1;
      repeat (8) @(posedge mclk);
      #1 ev[i] = 1'b0;
      repeat (8) @(posedge mclk);
      wr_chk(8'hb3 + k, 8'h00, 1'b1);
      rd_chk(8'hb3 + k, {2'b11, 8'h01 << (i - 5 * k)});
      wr_chk(8'hb3 + k, 8'hff, 1'b1);
      rd_chk(8'hb3 + k, 10'h300);
    end
    // clear refused while the event stays high
    ev[5] = 1'b1;
    repeat (8) @(posedge mclk);
    wr_chk(8'hb4, 8'h01, 1'b1);
    rd_chk(8'hb4, 10'h301);
    ev[5] = 1'b0;
    repeat (8) @(posedge mclk);
    wr_chk(8'hb4, 8'h01, 1'b1);
    rd_chk(8'hb4, 10'h300);
    // all hot sites, a partial clear, then stray writes
    ev[14:10] = 5'h1f;
    repeat (8) @(posedge mclk);
    #1 ev[14:10] = 5'h00;
    repeat (8) @(posedge mclk);
    wr_chk(8'hb5, 8'h0a, 1'b1);
    rd_chk(8'hb5, 10'h315);
    wr_chk(8'hb7, 8'hff, 1'b0);
    wr_chk(8'hb2, 8'hff, 1'b0);
    rd_chk(8'hb5, 10'h315);
    // a second reset clears every latched flag
    ev = 18'h3ffff;
    repeat (8) @(posedge mclk);
    #1 ev = 18'h0;
    repeat (8) @(posedge mclk);
    for (i = 0; i < 4; i = i + 1)
      rd_chk(8'hb3 + i[7:0], (i == 3) ? 10'h307 : 10'h31f);
    nrst = 1'b0;
    repeat (6) @(posedge mclk);
    #1 nrst = 1'b1;
    for (i = 0; i < 4; i = i + 1)
      rd_chk(8'hb3 + i[7:0], 10'h300);
    tally_and_finish;
  end
endmodule // test_fault_thermal_status_bank
